// File: design/gppc_port.sv
// five-pin port: ahb-lite registers, pin config, sampling, edges
// assumes one 25 MHz mclk, a synchronous rst and a power-up reset
//
// How it works
// - set command applies, acknowledged with code 62h
// - pin index 0..4 only, others refused
// - output state 0 drives level low
// - state 1..99 gives 100 Hz pwm duty
// - state 100 high, above 100 refused
// - config byte 0..15: mode bits, function bit
// - drive mode codes set pad strengths
// - function bit clear selects default function
// - function bit set selects user output
// - pins sampled at about 32 Hz while ce is high
// - rising and falling edges remembered per pin
// - pull-up mode with open switch reads 1
// - config saved as boot state, restored later
// - defaults: sense, power, reset, one-wire pins
// - query word: state, falling, rising bits
`timescale 1ns/10ps
module gppc_port #(
	parameter int unsigned SAMPLE_CYC = gppc_pkg::SAMPLE_CYC
) (
	// clock, resets, enable
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        por,
	input  wire logic        ce,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// default-function levels
	input  wire logic [4:0]  dflt_out,
	// pins
	input  wire logic [4:0]  gpio_in,
	output logic      [4:0]  gpio_out,
	output logic      [4:0]  gpio_oe,
	output logic      [4:0]  gpio_pull_up,
	output logic      [4:0]  gpio_pull_dn,
	output logic      [4:0]  gpio_slow,
	output logic      [4:0]  pin_level
);

	// -------------------------------------------------------------
	// declarations
	// -------------------------------------------------------------
	gppc_pkg::gppc_cfg_t cur  [gppc_pkg::NPINS];
	gppc_pkg::gppc_cfg_t boot [gppc_pkg::NPINS];
	logic              take;
	logic [3:0]        asel;
	logic [3:0]        wsel;
	logic              wr_pend;
	logic              wr_set;
	logic              set_ok;
	logic [7:0]        set_idx;
	logic [7:0]        set_state;
	logic [7:0]        set_cfg;
	logic              set_cfg_en;
	logic [7:0]        qidx;
	logic [7:0]        q_eff;
	logic [4:0]        clr_mask;
	logic [7:0]        last_ack;
	logic              refused;
	logic [31:0]       next_rdata;
	logic [4:0]        sync1;
	logic [4:0]        sync2;
	logic [4:0]        rise;
	logic [4:0]        fall;
	logic              primed;
	logic [19:0]       scnt;
	logic              tick;
	logic [11:0]       pre;
	logic [6:0]        phase;

	// -------------------------------------------------------------
	// decode
	// -------------------------------------------------------------
	// one-hot select {status, store, query, set}, zero if unmapped
	function automatic logic [3:0] gppc_decode(input logic [31:0] a);
		if (a[31:8] != 24'h000000) begin
			return 4'h0;
		end else if (a[7:0] == gppc_pkg::OFS_SET) begin
			return 4'h1;
		end else if (a[7:0] == gppc_pkg::OFS_QUERY) begin
			return 4'h2;
		end else if (a[7:0] == gppc_pkg::OFS_STORE) begin
			return 4'h4;
		end else if (a[7:0] == gppc_pkg::OFS_STATUS) begin
			return 4'h8;
		end else begin
			return 4'h0;
		end
	endfunction : gppc_decode

	assign take = ce & hsel & hready & htrans[1];
	assign asel = gppc_decode(haddr);

	// -------------------------------------------------------------
	// ahb-lite slave
	// -------------------------------------------------------------
	// address phase capture for the write data phase
	always_ff @(posedge mclk) begin
		if (rst) begin
			wr_pend <= 1'b0;
			wsel    <= 4'h0;
		end else if (ce) begin
			wr_pend <= take & hwrite;
			if (take) begin
				wsel <= asel;
			end
		end
	end

	// zero-wait, always okay
	always_ff @(posedge mclk) begin
		if (rst) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// read data registered at the address phase
	always_ff @(posedge mclk) begin
		if (rst) begin
			hrdata <= 32'h00000000;
		end else if (take && !hwrite) begin
			hrdata <= next_rdata;
		end
	end

	// -------------------------------------------------------------
	// set command fields
	// -------------------------------------------------------------
	assign wr_set     = wr_pend & wsel[0];
	assign set_idx    = hwdata[7:0];
	assign set_state  = hwdata[gppc_pkg::SET_STATE_LSB +: 8];
	assign set_cfg    = hwdata[gppc_pkg::SET_CFG_LSB +: 8];
	assign set_cfg_en = hwdata[gppc_pkg::SET_CFG_EN];

	// refuse bad index, state or config byte
	assign set_ok = (set_idx < gppc_pkg::IDX_LIMIT) &&
		(set_state <= gppc_pkg::STATE_HI) &&
		(!set_cfg_en || set_cfg <= gppc_pkg::CFG_MAX);

	// -------------------------------------------------------------
	// pin configuration and boot copy
	// -------------------------------------------------------------
	// live config: factory at power up, boot copy at reset
	always_ff @(posedge mclk) begin
		if (por) begin
			cur <= gppc_pkg::CFG_DFLT;
		end else if (rst) begin
			cur <= boot;
		end else if (ce && wr_set && set_ok) begin
			cur[set_idx[2:0]].state <= set_state;
			if (set_cfg_en) begin
				cur[set_idx[2:0]].func <= set_cfg[3];
				cur[set_idx[2:0]].mode <= set_cfg[2:0];
			end
		end
	end

	// store-boot-state write copies the live config
	always_ff @(posedge mclk) begin
		if (por) begin
			boot <= gppc_pkg::CFG_DFLT;
		end else if (ce && wr_pend && wsel[2] && hwdata[0]) begin
			boot <= cur;
		end
	end

	// acknowledge of the last set command
	always_ff @(posedge mclk) begin
		if (rst) begin
			last_ack <= gppc_pkg::ACK_NONE;
			refused  <= 1'b0;
		end else if (ce && wr_set) begin
			last_ack <= set_ok ? gppc_pkg::ACK_SET : gppc_pkg::ACK_NONE;
			refused  <= !set_ok;
		end
	end

	// -------------------------------------------------------------
	// query
	// -------------------------------------------------------------
	// forward a pending index write to a read right behind it
	assign q_eff = (wr_pend && wsel[1]) ? hwdata[7:0] : qidx;

	always_ff @(posedge mclk) begin
		if (rst) begin
			qidx <= 8'h00;
		end else if (ce && wr_pend && wsel[1]) begin
			qidx <= hwdata[7:0];
		end
	end

	// edge flags of the reported pin are cleared by the read
	always_comb begin
		clr_mask = 5'h00;
		if (take && !hwrite && asel[1] && q_eff < gppc_pkg::IDX_LIMIT) begin
			clr_mask[q_eff[2:0]] = 1'b1;
		end
	end

	// read mux
	always_comb begin
		next_rdata = 32'h00000000;
		if (asel[1]) begin
			next_rdata[7:0] = q_eff;
			if (q_eff < gppc_pkg::IDX_LIMIT) begin
				next_rdata[10:8]  = {rise[q_eff[2:0]], fall[q_eff[2:0]],
					pin_level[q_eff[2:0]]};
				next_rdata[23:16] = cur[q_eff[2:0]].state;
				next_rdata[27:24] = {cur[q_eff[2:0]].func, cur[q_eff[2:0]].mode};
			end
		end else if (asel[3]) begin
			next_rdata[7:0]                    = last_ack;
			next_rdata[gppc_pkg::STAT_REFUSED] = refused;
		end
	end

	// -------------------------------------------------------------
	// input sampling and edges
	// -------------------------------------------------------------
	// two-stage synchroniser on the pins
	always_ff @(posedge mclk) begin
		if (rst) begin
			sync1 <= 5'h00;
			sync2 <= 5'h00;
		end else if (ce) begin
			sync1 <= gpio_in;
			sync2 <= sync1;
		end
	end

	// free-running sample timer
	assign tick = (scnt == 20'(SAMPLE_CYC - 1));

	always_ff @(posedge mclk) begin
		if (rst) begin
			scnt <= 20'h00000;
		end else if (ce) begin
			scnt <= tick ? 20'h00000 : scnt + 20'h00001;
		end
	end

	// sampled level; first sample only primes the compare
	always_ff @(posedge mclk) begin
		if (rst) begin
			pin_level <= 5'h00;
			primed    <= 1'b0;
		end else if (ce && tick) begin
			pin_level <= sync2;
			primed    <= 1'b1;
		end
	end

	// sticky edges, a new edge wins over the clear
	always_ff @(posedge mclk) begin
		if (rst) begin
			rise <= 5'h00;
			fall <= 5'h00;
		end else if (ce) begin
			rise <= (rise & ~clr_mask) |
				({5{tick & primed}} & sync2 & ~pin_level);
			fall <= (fall & ~clr_mask) |
				({5{tick & primed}} & ~sync2 & pin_level);
		end
	end

	// -------------------------------------------------------------
	// pwm timebase
	// -------------------------------------------------------------
	// 100 steps of 100 us give the 100 Hz frame
	always_ff @(posedge mclk) begin
		if (rst) begin
			pre   <= 12'h000;
			phase <= 7'h00;
		end else if (ce) begin
			if (pre == 12'(gppc_pkg::PWM_STEP_CYC - 1)) begin
				pre   <= 12'h000;
				phase <= (phase == gppc_pkg::PWM_LAST) ? 7'h00 : phase + 7'h01;
			end else begin
				pre <= pre + 12'h001;
			end
		end
	end

	// -------------------------------------------------------------
	// pin drivers
	// -------------------------------------------------------------
	gppc_pin_if pif [gppc_pkg::NPINS] ();

	for (genvar i = 0; i < gppc_pkg::NPINS; i++) begin : g_pin
		assign pif[i].duty  = cur[i].state;
		assign pif[i].func  = cur[i].func;
		assign pif[i].mode  = cur[i].mode;
		assign pif[i].phase = phase;
		assign pif[i].dflt  = dflt_out[i];
		gppc_pin u_pin (
			.mclk     (mclk),
			.rst      (rst),
			.ce       (ce),
			.pif      (pif[i]),
			.pad_out  (gpio_out[i]),
			.pad_oe   (gpio_oe[i]),
			.pad_pu   (gpio_pull_up[i]),
			.pad_pd   (gpio_pull_dn[i]),
			.pad_slow (gpio_slow[i])
		);
	end

	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst || por);

	a_bus_okay: assert property (
		take |=> hreadyout && (hresp == 1'b0))
		else $error("slave not ready or not okay");
	a_reply_type: assert property (
		(ce && wr_set && set_ok) |=> (last_ack == 8'h62) && !refused)
		else $error("good set not acknowledged");
	a_bad_index: assert property (
		(ce && wr_set && hwdata[7:0] >= 8'h05) |=> refused && (last_ack == 8'h00))
		else $error("reserved index accepted");
	a_bad_state: assert property (
		(ce && wr_set && hwdata[15:8] > 8'h64) |=> refused)
		else $error("invalid state accepted");
	a_bad_cfg: assert property (
		(ce && wr_set && hwdata[24] && hwdata[23:16] > 8'h0F) |=> refused)
		else $error("reserved config bits accepted");
	a_state_store: assert property (
		(ce && wr_set && set_ok && hwdata[7:0] == 8'h00)
		|=> cur[0].state == $past(hwdata[15:8]))
		else $error("pin 0 state not stored");
	a_rise_flag: assert property (
		(ce && tick && primed && (sync2 & ~pin_level) != 5'h00)
		|=> (rise & $past(sync2 & ~pin_level)) == $past(sync2 & ~pin_level))
		else $error("rising edge not remembered");
	a_edge_clear: assert property (
		(ce && clr_mask != 5'h00 && !tick)
		|=> ((rise | fall) & $past(clr_mask)) == 5'h00)
		else $error("edge flags not cleared by query");
	a_boot_load: assert property (
		disable iff (por) (rst ##1 !rst) |-> cur[1] == $past(boot[1]))
		else $error("boot state not restored");

	c_set_ok: cover property (ce && wr_set && set_ok);
	c_refused: cover property (ce && wr_set && !set_ok);
	c_edge_read: cover property ((rise != 5'h00) ##[1:20] (clr_mask != 5'h00));

endmodule : gppc_port

// File: design/gppc_pkg.sv
// constants and types of the five-pin port with pwm outputs
// assumes a 25 MHz mclk shared by every module of the port
package gppc_pkg;

	// pin count, packet codes and set command limits
	localparam int unsigned NPINS     = 5;
	localparam logic [7:0]  CMD_SET   = 8'h22;
	localparam logic [7:0]  ACK_SET   = 8'h62;
	localparam logic [7:0]  CMD_READ  = 8'h23;
	localparam logic [7:0]  ACK_NONE  = 8'h00;
	localparam logic [7:0]  STATE_HI  = 8'h64;
	localparam logic [7:0]  CFG_MAX   = 8'h0F;
	localparam logic [7:0]  IDX_LIMIT = 8'h05;

	// register byte offsets
	localparam logic [7:0]  OFS_SET    = 8'h00;
	localparam logic [7:0]  OFS_QUERY  = 8'h04;
	localparam logic [7:0]  OFS_STORE  = 8'h08;
	localparam logic [7:0]  OFS_STATUS = 8'h0C;

	// field positions of the set and status words
	localparam int unsigned SET_STATE_LSB = 8;
	localparam int unsigned SET_CFG_LSB   = 16;
	localparam int unsigned SET_CFG_EN    = 24;
	localparam int unsigned STAT_REFUSED  = 8;

	// drive modes
	localparam logic [2:0]  DM_UP_PD   = 3'h0;
	localparam logic [2:0]  DM_STRONG  = 3'h1;
	localparam logic [2:0]  DM_HIZ     = 3'h2;
	localparam logic [2:0]  DM_PU_DN   = 3'h3;
	localparam logic [2:0]  DM_SUP_HIZ = 3'h4;
	localparam logic [2:0]  DM_SLOW    = 3'h5;
	localparam logic [2:0]  DM_HIZ_SDN = 3'h7;

	// timing
	localparam int unsigned CLK_NS       = 40;
	localparam int unsigned PWM_STEP_NS  = 100000;
	localparam int unsigned PWM_STEP_CYC = PWM_STEP_NS / CLK_NS;
	localparam logic [6:0]  PWM_LAST     = 7'h63;
	localparam int unsigned SAMPLE_NS    = 31250000;
	localparam int unsigned SAMPLE_CYC   = SAMPLE_NS / CLK_NS;

	// stored configuration of one pin
	typedef struct packed {
		logic [7:0] state;
		logic       func;
		logic [2:0] mode;
	} gppc_cfg_t;

	// factory values after power up
	localparam gppc_cfg_t CFG_DFLT [NPINS] = '{
		'{8'h00, 1'b0, DM_HIZ},
		'{8'h00, 1'b0, DM_PU_DN},
		'{8'h00, 1'b0, DM_HIZ},
		'{8'h00, 1'b0, DM_HIZ},
		'{8'h00, 1'b0, DM_HIZ_SDN}
	};

endpackage : gppc_pkg

// File: design/gppc_pin_if.sv
// settings handed from the port control to one pin driver
// assumes both ends run on the same mclk
`timescale 1ns/10ps
interface gppc_pin_if;
	logic [7:0] duty;
	logic       func;
	logic [2:0] mode;
	logic [6:0] phase;
	logic       dflt;
	modport ctrl (output duty, func, mode, phase, dflt);
	modport pin  (input duty, func, mode, phase, dflt);
endinterface : gppc_pin_if

// File: design/gppc_pin.sv
// one pin driver: level select, pwm compare and drive mode
// assumes settings arrive on mclk from the port control
`timescale 1ns/10ps
module gppc_pin (
	// clock and control
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic ce,
	// settings
	gppc_pin_if.pin   pif,
	// pad controls
	output logic      pad_out,
	output logic      pad_oe,
	output logic      pad_pu,
	output logic      pad_pd,
	output logic      pad_slow
);

	logic lvl;
	logic next_out;
	logic next_oe;
	logic next_pu;
	logic next_pd;
	logic next_slow;

	// -------------------------------------------------------------
	// level of the pin
	// -------------------------------------------------------------
	// user pwm level or default-function level
	always_comb begin
		if (!pif.func) begin
			lvl = pif.dflt;
		end else if (pif.duty == 8'h00) begin
			lvl = 1'b0;
		end else if (pif.duty >= gppc_pkg::STATE_HI) begin
			lvl = 1'b1;
		end else begin
			lvl = ({1'b0, pif.phase} < pif.duty);
		end
	end

	// -------------------------------------------------------------
	// drive mode
	// -------------------------------------------------------------
	// per-mode strength for high and low
	always_comb begin
		next_out  = lvl;
		next_oe   = 1'b0;
		next_pu   = 1'b0;
		next_pd   = 1'b0;
		next_slow = 1'b0;
		case (pif.mode)
			gppc_pkg::DM_UP_PD: begin
				next_oe = lvl;
				next_pd = !lvl;
			end
			gppc_pkg::DM_STRONG: begin
				next_oe = 1'b1;
			end
			gppc_pkg::DM_PU_DN: begin
				next_oe = !lvl;
				next_pu = lvl;
			end
			gppc_pkg::DM_SUP_HIZ: begin
				next_oe   = lvl;
				next_slow = 1'b1;
			end
			gppc_pkg::DM_SLOW: begin
				next_oe   = 1'b1;
				next_slow = 1'b1;
			end
			gppc_pkg::DM_HIZ_SDN: begin
				next_oe   = !lvl;
				next_slow = 1'b1;
			end
			default: begin
				next_oe = 1'b0; // input, and unused code
			end
		endcase
	end

	// registered pad controls, released after reset
	always_ff @(posedge mclk) begin
		if (rst) begin
			pad_out  <= 1'b0;
			pad_oe   <= 1'b0;
			pad_pu   <= 1'b0;
			pad_pd   <= 1'b0;
			pad_slow <= 1'b0;
		end else if (ce) begin
			pad_out  <= next_out;
			pad_oe   <= next_oe;
			pad_pu   <= next_pu;
			pad_pd   <= next_pd;
			pad_slow <= next_slow;
		end
	end

	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	a_pwm_zero_low: assert property (
		(ce && pif.func && pif.duty == 8'h00 && pif.mode == 3'h1) |=> pad_oe && !pad_out)
		else $error("duty 0 did not drive low");
	a_pwm_full_high: assert property (
		(ce && pif.func && pif.duty == 8'h64 && pif.mode == 3'h1) |=> pad_oe && pad_out)
		else $error("duty 100 did not drive high");
	a_pwm_duty_cmp: assert property (
		(ce && pif.func && pif.mode == 3'h1 && pif.duty != 8'h00 && pif.duty < 8'h64)
		|=> pad_out == ({1'b0, $past(pif.phase)} < $past(pif.duty)))
		else $error("pwm level wrong for phase");
	a_hiz_input: assert property (
		(ce && pif.mode == 3'h2) |=> !pad_oe && !pad_pu && !pad_pd)
		else $error("input mode drives the pin");
	a_pull_up_high: assert property (
		(ce && pif.mode == 3'h3 && lvl) |=> pad_pu && !pad_oe)
		else $error("pull-up high not resistive");
	a_dflt_level: assert property (
		(ce && !pif.func && pif.mode == 3'h1) |=> pad_out == $past(pif.dflt))
		else $error("default function level not followed");

endmodule : gppc_pin

// File: verification/gppc_pad_world.sv
// outside world of the five pins: resolves each wire from the pads
// assumes bench switches to ground; pin 4 keeps a fixed pull-up
`timescale 1ns/10ps
module gppc_pad_world (
	// clock
	input  wire logic       mclk,
	// pad controls of the port
	input  wire logic [4:0] gpio_out,
	input  wire logic [4:0] gpio_oe,
	input  wire logic [4:0] gpio_pull_up,
	input  wire logic [4:0] gpio_pull_dn,
	// switches, closed pulls the pin low
	input  wire logic [4:0] sw_low,
	// resolved pin levels
	output logic      [4:0] gpio_in
);
	logic [4:0] float_pat = 5'h15;

	// an undriven wire wanders every cycle
	always @(posedge mclk) float_pat <= ~float_pat;

	// wire resolution, switch wins over any drive
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			if (sw_low[i]) gpio_in[i] = 1'b0;
			else if (gpio_oe[i]) gpio_in[i] = gpio_out[i];
			else if (gpio_pull_up[i] || i == 4) gpio_in[i] = 1'b1;
			else if (gpio_pull_dn[i]) gpio_in[i] = 1'b0;
			else gpio_in[i] = float_pat[i];
		end
	end
endmodule : gppc_pad_world

// File: verification/test_gppc_port.sv
// self-checking bench of the five-pin port, host side over ahb-lite
// assumes gppc_pad_world closes the pin wires
`timescale 1ns/10ps
module test_gppc_port;
	// ----------------------------------------
	// signals and reference model
	// ----------------------------------------
	localparam int SC = 16;
	logic        mclk = 1'b0;
	logic        rst, por, ce, hsel, hwrite, hreadyout, hresp;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata;
	logic [4:0]  dflt_out, gpio_in, gpio_out, gpio_oe, pu, pd, slow, pin_level, sw_low;
	int          err_total, n_checks, cyc, lvl_ok;
	int          m_st[5], m_cf[5], b_st[5], b_cf[5];
	logic        m_lvl, m_fall, m_rise;
	int          modes[7] = '{0, 1, 2, 3, 4, 5, 7};
	int          ua[4] = '{0, 8, 'h10, 'h104};

	// 25 MHz clock and cycle count
	always #20 mclk = ~mclk;
	always @(posedge mclk) cyc <= cyc + 1;

	gppc_port #(.SAMPLE_CYC(SC)) uut (
		.mclk(mclk), .rst(rst), .por(por), .ce(ce), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.dflt_out(dflt_out), .gpio_in(gpio_in), .gpio_out(gpio_out),
		.gpio_oe(gpio_oe), .gpio_pull_up(pu), .gpio_pull_dn(pd),
		.gpio_slow(slow), .pin_level(pin_level));
	gppc_pad_world world (.mclk(mclk), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
		.gpio_pull_up(pu), .gpio_pull_dn(pd), .sw_low(sw_low), .gpio_in(gpio_in));

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : conclude

	task automatic check(input string what, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// factory configuration in live and boot copy
	task automatic factory();
		m_st = '{0, 0, 0, 0, 0};
		m_cf = '{2, 3, 2, 2, 7};
		b_st = m_st;
		b_cf = m_cf;
	endtask : factory

	// one single transfer, address phase then data phase
	task automatic bus(input logic wr, input logic [31:0] a, d, output logic [31:0] r);
		int n;
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= a;
		hwrite <= wr;
		hsize  <= 3'h2;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		htrans <= 2'h0;
		hsel   <= 1'b0;
		hwdata <= d;
		do begin
			@(posedge mclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 40);
		r = hrdata;
		if (n >= 40) begin
			err_total++;
			conclude();
		end
		check("hresp", hresp, 0);
	endtask : bus

	// set command with model update and status check
	task automatic set_pin(input int i, s, c, p);
		logic [31:0] r;
		logic        ok;
		ok = i < 5 && s <= 100 && (p == 0 || c <= 15);
		bus(1, gppc_pkg::OFS_SET, {7'h00, p[0], c[7:0], s[7:0], i[7:0]}, r);
		if (ok) begin
			m_st[i] = s;
			if (p != 0) m_cf[i] = c;
		end
		bus(0, gppc_pkg::OFS_STATUS, 0, r);
		check("status", r, ok ? 32'h62 : 32'h100);
	endtask : set_pin

	// query one pin; levels of pins left floating are masked
	task automatic query(input int i);
		logic [31:0] r, e;
		bus(1, gppc_pkg::OFS_QUERY, i, r);
		bus(0, gppc_pkg::OFS_QUERY, 0, r);
		e = i;
		if (i < 5) begin
			e = {4'h0, m_cf[i][3:0], m_st[i][7:0], 5'h00, m_rise, m_fall, m_lvl, i[7:0]};
		end
		if (lvl_ok == 0 || i != 0) begin
			r[10:8] = 3'h0;
			e[10:8] = 3'h0;
		end
		check("query", r, e);
		if (i == 0) {m_rise, m_fall} = 2'b00;
	endtask : query

	// wait for pin 0 sample to reach v, track expected edges
	task automatic wait_lvl(input logic v);
		int n;
		n = 0;
		while (pin_level[0] !== v && n < 3 * SC) begin
			@(negedge mclk);
			n++;
		end
		if (n >= 3 * SC) begin
			err_total++;
			conclude();
		end
		@(posedge mclk);
		m_fall = m_fall | (m_lvl & ~v);
		m_rise = m_rise | (~m_lvl & v);
		m_lvl = v;
	endtask : wait_lvl

	// expected {out, oe, pull_up, pull_dn, slow} per drive mode
	function automatic logic [4:0] pad_exp(input int m, input logic l);
		case (m)
			0: pad_exp = l ? 5'h18 : 5'h02;
			1: pad_exp = {l, 4'h8};
			2: pad_exp = 5'h00;
			3: pad_exp = l ? 5'h04 : 5'h08;
			4: pad_exp = l ? 5'h19 : 5'h01; // slow select stays on while released
			5: pad_exp = {l, 4'h9};
			default: pad_exp = l ? 5'h01 : 5'h09;
		endcase
	endfunction : pad_exp

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] r;
		int          d, t0, n, i, s, p;
		{rst, por, ce, hsel, hwrite} = 5'b11100;
		htrans = 2'h0;
		hsize = 3'h2;
		haddr = 32'h0;
		hwdata = 32'h0;
		dflt_out = 5'h00;
		sw_low = 5'h00;
		{err_total, n_checks, lvl_ok} = 0;
		{m_lvl, m_fall, m_rise} = 3'b000;
		d = $urandom(72);
		factory();
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		por <= 1'b0;
		t0 = cyc;
		// pwm width of the first frame after reset
		d = $urandom_range(12, 1);
		set_pin(0, d, 'h09, 1);
		check("pwm high", gpio_out[0], 1);
		n = 0;
		while (gpio_out[0] !== 1'b0 && n < 40000) begin
			@(posedge mclk);
			n++;
		end
		n = cyc - t0;
		check("pwm width", n > d * 2500 - 6 && n < d * 2500 + 6, 1);
		$display("test pwm done");
		// every drive mode at both levels
		foreach (modes[k]) begin
			for (s = 0; s <= 100; s += 100) begin
				set_pin(0, s, 8 + modes[k], 1);
				repeat (2) @(posedge mclk);
				r = {gpio_oe[0] & gpio_out[0], gpio_oe[0], pu[0], pd[0], slow[0]};
				check("pads", r, pad_exp(modes[k], s != 0));
			end
		end
		$display("test drive modes done");
		// default function follows its own level
		set_pin(0, 100, 1, 1);
		repeat (4) begin
			dflt_out <= 5'($urandom);
			repeat (3) @(posedge mclk);
			check("default level", gpio_out[0], dflt_out[0]);
		end
		// unmapped and write-only places read zero, writes there ignored
		bus(1, 32'h104, 32'h3200, r);
		foreach (ua[k]) begin
			bus(0, ua[k], 0, r);
			check("unmapped", r, 0);
		end
		query(0);
		$display("test default and map done");
		// random set commands, refused ones included
		repeat (40) begin
			i = $urandom_range(6);
			s = $urandom_range(110);
			d = $urandom_range(20);
			if (d % 8 == 6) d--;
			p = (i inside {[1:3]}) ? 0 : $urandom_range(1);
			set_pin(i, s, d, p);
			query(i);
		end
		$display("test random sets done");
		// pull-up input with a switch to ground
		set_pin(0, 100, 'h0B, 1);
		repeat (3 * SC) @(posedge mclk);
		query(0);
		lvl_ok = 1;
		m_lvl = 1'b1;
		sw_low <= 5'h01;
		wait_lvl(0);
		query(0);
		query(0);
		sw_low <= 5'h00;
		wait_lvl(1);
		sw_low <= 5'h01;
		wait_lvl(0);
		query(0);
		// clock enable low freezes sampling, pickup resumes after
		ce <= 1'b0;
		sw_low <= 5'h00;
		repeat (3 * SC) @(posedge mclk);
		check("frozen level", pin_level[0], 0);
		ce <= 1'b1;
		wait_lvl(1);
		query(0);
		$display("test sampling done");
		// boot copy survives reset, factory values after power-up reset
		set_pin(0, 55, 'h0D, 1);
		bus(1, gppc_pkg::OFS_STORE, 1, r);
		b_st = m_st;
		b_cf = m_cf;
		set_pin(0, 9, 'h08, 1);
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		m_st = b_st;
		m_cf = b_cf;
		lvl_ok = 0;
		bus(0, gppc_pkg::OFS_STATUS, 0, r);
		check("status after reset", r, 0);
		query(0);
		por <= 1'b1;
		repeat (2) @(posedge mclk);
		por <= 1'b0;
		factory();
		for (i = 0; i < 5; i++) query(i);
		$display("test boot state done");
		conclude();
	end
endmodule : test_gppc_port
